// ---- hw/crq_top.v ----
// Card reply capture and transmit/receive byte queues behind a classic Wishbone slave.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "crq_defines.vh"

// Operation
// - Capture last reply index; R3 replies show all ones.
// - R1, R1b, R6 replies fill only word 0 with card status.
// - Long identification reply stored as bits 39:8 up to 127:104 in four words.
// - Writing one to bit 31 empties the receive queue; reads zero.
// - Writing one to bit 30 empties the transmit queue; reads zero.
// - Bits 15:8 report bytes held in the receive queue.
// - Bits 7:0 report free transmit bytes, 128 after reset.
// - Receive flag and interrupt when held bytes reach level 15:8, reset 0x40.
// - Transmit flag and interrupt when held bytes reach level 7:0, reset 0x40.
// - Any write inside 0x1000 to 0x1fff pushes the single transmit queue.
// - Transmit writes that do not fit push nothing and set the overflow status.
// - Byte, half-word and word writes push one, two or four bytes.
// - Byte, half-word and word reads of receive window pop one, two or four.
module crq_top #(
    parameter DEPTH_LOG2 = 7
) (
    input  wire          CORE_CLK,
    input  wire          RSTN,
    input  wire          WB_CYC_I,
    input  wire          WB_STB_I,
    input  wire          WB_WE_I,
    input  wire [13:0]   WB_ADR_I,
    input  wire [3:0]    WB_SEL_I,
    input  wire [31:0]   WB_DAT_I,
    output reg  [31:0]   WB_DAT_O,
    output reg           WB_ACK_O,
    output wire          IRQ,
    input  wire          REPLY_VALID,
    input  wire [2:0]    REPLY_TYPE,
    input  wire [5:0]    REPLY_INDEX,
    input  wire [127:0]  REPLY_BITS,
    output wire          TX_VALID,
    input  wire          TX_READY,
    output wire [7:0]    TX_DATA,
    input  wire          RX_VALID,
    output wire          RX_READY,
    input  wire [7:0]    RX_DATA
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    localparam [8:0] DEPTH_CNT = 9'h001 << DEPTH_LOG2;

    reg  [7:0]              tx_mem [0:DEPTH-1];
    reg  [7:0]              rx_mem [0:DEPTH-1];
    reg  [DEPTH_LOG2-1:0]   tx_wp_q;
    reg  [DEPTH_LOG2-1:0]   tx_rp_q;
    reg  [DEPTH_LOG2-1:0]   rx_wp_q;
    reg  [DEPTH_LOG2-1:0]   rx_rp_q;
    reg  [8:0]              tx_cnt_q;
    reg  [8:0]              rx_cnt_q;
    reg  [5:0]              index_q;
    reg  [31:0]             reply0_q;
    reg  [31:0]             reply1_q;
    reg  [31:0]             reply2_q;
    reg  [23:0]             reply3_q;
    reg  [15:0]             level_q;
    reg  [`CRQ_IRQ_W-1:0]   irq_stat_q;
    reg  [`CRQ_IRQ_W-1:0]   irq_mask_q;
    reg                     rx_flag_q;
    reg                     tx_flag_q;

    // Lane offsets: number of selected lanes below each lane, two bits each.
    function [7:0] lane_offsets;
        input [3:0] sel;
        begin
            lane_offsets[1:0] = 2'h0;
            lane_offsets[3:2] = {1'b0, sel[0]};
            lane_offsets[5:4] = {1'b0, sel[0]} + {1'b0, sel[1]};
            lane_offsets[7:6] = {1'b0, sel[0]} + {1'b0, sel[1]} + {1'b0, sel[2]};
        end
    endfunction

    function [2:0] lane_count;
        input [3:0] sel;
        begin
            lane_count = {2'h0, sel[0]} + {2'h0, sel[1]} + {2'h0, sel[2]} + {2'h0, sel[3]};
        end
    endfunction

    wire        req      = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire [1:0]  win      = WB_ADR_I[`CRQ_WIN_SEL_HI:`CRQ_WIN_SEL_LO];
    wire [13:0] reg_addr = {WB_ADR_I[13:2], 2'h0};
    wire [7:0]  offs     = lane_offsets(WB_SEL_I);
    wire [2:0]  nbytes   = lane_count(WB_SEL_I);
    wire [8:0]  tx_free  = DEPTH_CNT - tx_cnt_q;

    wire wr_qstat  = req & WB_WE_I & (reg_addr == `CRQ_OFF_QSTAT) & WB_SEL_I[3];
    wire rx_purge  = wr_qstat & WB_DAT_I[`CRQ_BIT_RX_PURGE];
    wire tx_purge  = wr_qstat & WB_DAT_I[`CRQ_BIT_TX_PURGE];

    // Whole window decodes to one queue.
    wire tx_wr     = req & WB_WE_I & (win == `CRQ_WIN_TX);
    wire tx_fits   = {6'h0, nbytes} <= tx_free;
    wire tx_push   = tx_wr & tx_fits & ~tx_purge;
    wire tx_over   = tx_wr & ~tx_fits;
    wire rx_rd     = req & ~WB_WE_I & (win == `CRQ_WIN_RX);
    wire rx_fits   = {6'h0, nbytes} <= rx_cnt_q;
    wire rx_pop    = rx_rd & rx_fits & ~rx_purge;
    wire rx_under  = rx_rd & ~rx_fits;

    wire tx_drain  = TX_VALID & TX_READY;
    wire rx_fill   = RX_VALID & RX_READY;
    assign TX_VALID = tx_cnt_q != 9'h000;
    assign TX_DATA  = tx_mem[tx_rp_q];
    assign RX_READY = rx_cnt_q != DEPTH_CNT;

    reg  [8:0]              tx_cnt_d;
    reg  [8:0]              rx_cnt_d;

    // Next transmit fill; a purge beats a push or a drain in the same cycle.
    always @* begin
        if (tx_purge) begin
            tx_cnt_d = 9'h000;
        end else begin
            tx_cnt_d = tx_cnt_q;
            if (tx_push) begin
                tx_cnt_d = tx_cnt_d + {6'h0, nbytes};
            end
            if (tx_drain) begin
                tx_cnt_d = tx_cnt_d - 9'h001;
            end
        end
    end

    // Next receive fill; a purge beats a fill or a pop in the same cycle.
    always @* begin
        if (rx_purge) begin
            rx_cnt_d = 9'h000;
        end else begin
            rx_cnt_d = rx_cnt_q;
            if (rx_fill) begin
                rx_cnt_d = rx_cnt_d + 9'h001;
            end
            if (rx_pop) begin
                rx_cnt_d = rx_cnt_d - {6'h0, nbytes};
            end
        end
    end
    wire rx_flag_d = rx_cnt_d >= {1'b0, level_q[15:8]};
    wire tx_flag_d = tx_cnt_d >= {1'b0, level_q[7:0]};

    reg  [31:0]            rd_data;
    reg  [31:0]            rx_rd_data;
    reg  [`CRQ_IRQ_W-1:0]  irq_set;
    integer                i;

    // Lowest selected lane gets the oldest byte; an underflow reads zero.
    always @* begin
        rx_rd_data = 32'h0000_0000;
        for (i = 0; i < 4; i = i + 1) begin
            if (WB_SEL_I[i] && rx_fits) begin
                rx_rd_data[8*i +: 8] = rx_mem[rx_rp_q + {{(DEPTH_LOG2-2){1'b0}}, offs[2*i +: 2]}];
            end
        end
    end

    always @* begin
        rd_data = 32'h0000_0000;
        if (rx_rd) begin
            rd_data = rx_rd_data;
        end else if (win == 2'h0) begin
            case (reg_addr)
                `CRQ_OFF_LAST_INDEX: rd_data = {26'h0, index_q};
                `CRQ_OFF_REPLY0:     rd_data = reply0_q;
                `CRQ_OFF_REPLY1:     rd_data = reply1_q;
                `CRQ_OFF_REPLY2:     rd_data = reply2_q;
                `CRQ_OFF_REPLY3:     rd_data = {8'h00, reply3_q};
                `CRQ_OFF_QSTAT:      rd_data = {16'h0, rx_cnt_q[7:0], tx_free[7:0]};
                `CRQ_OFF_LEVEL:      rd_data = {16'h0, level_q};
                `CRQ_OFF_IRQ_STAT:   rd_data = {22'h0, tx_flag_q, rx_flag_q, 3'h0, irq_stat_q};
                `CRQ_OFF_IRQ_MASK:   rd_data = {27'h0, irq_mask_q};
                default:             rd_data = 32'h0000_0000;
            endcase
        end
    end

    always @* begin
        irq_set = {`CRQ_IRQ_W{1'b0}};
        irq_set[`CRQ_IRQ_RX_LEVEL] = rx_flag_d & ~rx_flag_q;
        irq_set[`CRQ_IRQ_TX_LEVEL] = tx_flag_d & ~tx_flag_q;
        irq_set[`CRQ_IRQ_REPLY]    = REPLY_VALID;
        irq_set[`CRQ_IRQ_TX_OVER]  = tx_over;
        irq_set[`CRQ_IRQ_RX_UNDER] = rx_under;
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

    wire wr_level = req & WB_WE_I & (reg_addr == `CRQ_OFF_LEVEL);
    wire wr_istat = req & WB_WE_I & (reg_addr == `CRQ_OFF_IRQ_STAT) & WB_SEL_I[0];
    wire wr_imask = req & WB_WE_I & (reg_addr == `CRQ_OFF_IRQ_MASK) & WB_SEL_I[0];
    wire [`CRQ_IRQ_W-1:0] irq_clr = wr_istat ? WB_DAT_I[`CRQ_IRQ_W-1:0] : {`CRQ_IRQ_W{1'b0}};
    // Pointer step is the lane count widened to the pointer size.
    wire [DEPTH_LOG2-1:0] lane_step = {{(DEPTH_LOG2-3){1'b0}}, nbytes};

    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req;
            WB_DAT_O <= req ? rd_data : 32'h0000_0000;
        end
    end

    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_flag_q <= 1'b0;
            tx_flag_q <= 1'b0;
        end else begin
            rx_flag_q <= rx_flag_d;
            tx_flag_q <= tx_flag_d;
        end
    end

    // Level bytes are written lane by lane.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            level_q <= `CRQ_LEVEL_RESET;
        end else begin
            if (wr_level && WB_SEL_I[0]) begin
                level_q[7:0] <= WB_DAT_I[7:0];
            end
            if (wr_level && WB_SEL_I[1]) begin
                level_q[15:8] <= WB_DAT_I[15:8];
            end
        end
    end

    // Interrupt enables, one per status bit.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_mask_q <= {`CRQ_IRQ_W{1'b0}};
        end else if (wr_imask) begin
            irq_mask_q <= WB_DAT_I[`CRQ_IRQ_W-1:0];
        end
    end

    // A new event in the clearing cycle stays set, so a late clear cannot hide it.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_stat_q <= {`CRQ_IRQ_W{1'b0}};
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // Index or all ones for R3.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            index_q <= 6'h00;
        end else if (REPLY_VALID) begin
            index_q <= (REPLY_TYPE == `CRQ_RTYPE_R3) ? `CRQ_INDEX_R3 : REPLY_INDEX;
        end
    end

    // Word 0 holds the card status of a short reply or the low part of a long one.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            reply0_q <= 32'h0000_0000;
        end else if (REPLY_VALID) begin
            reply0_q <= REPLY_BITS[39:8];
        end
    end

    // Upper reply words.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            reply1_q <= 32'h0000_0000;
            reply2_q <= 32'h0000_0000;
            reply3_q <= 24'h00_0000;
        end else if (REPLY_VALID) begin
            if (REPLY_TYPE == `CRQ_RTYPE_R2) begin
                reply1_q <= REPLY_BITS[71:40];
                reply2_q <= REPLY_BITS[103:72];
                reply3_q <= REPLY_BITS[127:104];
            end else begin
                // Short reply clears the upper words.
                reply1_q <= 32'h0000_0000;
                reply2_q <= 32'h0000_0000;
                reply3_q <= 24'h00_0000;
            end
        end
    end

    // Transmit fill count.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_cnt_q <= 9'h000;
        end else begin
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // Receive fill count.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_cnt_q <= 9'h000;
        end else begin
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // Transmit pointers; a purge overrides traffic in the same cycle.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_wp_q <= {DEPTH_LOG2{1'b0}};
            tx_rp_q <= {DEPTH_LOG2{1'b0}};
        end else if (tx_purge) begin
            tx_wp_q <= {DEPTH_LOG2{1'b0}};
            tx_rp_q <= {DEPTH_LOG2{1'b0}};
        end else begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + lane_step;
            end
            if (tx_drain) begin
                tx_rp_q <= tx_rp_q + 1'b1;
            end
        end
    end

    // Receive pointers; a purge overrides traffic in the same cycle.
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_wp_q <= {DEPTH_LOG2{1'b0}};
            rx_rp_q <= {DEPTH_LOG2{1'b0}};
        end else if (rx_purge) begin
            rx_wp_q <= {DEPTH_LOG2{1'b0}};
            rx_rp_q <= {DEPTH_LOG2{1'b0}};
        end else begin
            if (rx_fill) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + lane_step;
            end
        end
    end

    // Storage has no reset; contents are only read behind a nonzero count.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            always @(posedge CORE_CLK) begin
                if (tx_push && WB_SEL_I[g])
                    tx_mem[tx_wp_q + {{(DEPTH_LOG2-2){1'b0}}, offs[2*g +: 2]}]
                        <= WB_DAT_I[8*g +: 8];
            end
        end
    endgenerate

    always @(posedge CORE_CLK) begin
        if (rx_fill && !rx_purge) begin
            rx_mem[rx_wp_q] <= RX_DATA;
        end
    end

endmodule // crq_top

// ---- hw/crq_defines.vh ----
// Register map, field positions and reset values of the card reply and data queue.
`ifndef CRQ_DEFINES_VH
`define CRQ_DEFINES_VH
`define CRQ_OFF_LAST_INDEX   14'h0020
`define CRQ_OFF_REPLY0       14'h0024
`define CRQ_OFF_REPLY1       14'h0028
`define CRQ_OFF_REPLY2       14'h002c
`define CRQ_OFF_REPLY3       14'h0030
`define CRQ_OFF_QSTAT        14'h0034
`define CRQ_OFF_LEVEL        14'h0038
`define CRQ_OFF_IRQ_STAT     14'h003c
`define CRQ_OFF_IRQ_MASK     14'h0040
`define CRQ_TXWIN_BASE       14'h1000
`define CRQ_RXWIN_BASE       14'h2000
`define CRQ_WIN_SEL_HI       13
`define CRQ_WIN_SEL_LO       12
`define CRQ_WIN_TX           2'h1
`define CRQ_WIN_RX           2'h2
`define CRQ_BIT_RX_PURGE     31
`define CRQ_BIT_TX_PURGE     30
`define CRQ_LEVEL_RESET      16'h4040
`define CRQ_RTYPE_R1         3'h0
`define CRQ_RTYPE_R1B        3'h1
`define CRQ_RTYPE_R2         3'h2
`define CRQ_RTYPE_R3         3'h3
`define CRQ_INDEX_R3         6'h3f
`define CRQ_IRQ_W            5
`define CRQ_IRQ_RX_LEVEL     0
`define CRQ_IRQ_TX_LEVEL     1
`define CRQ_IRQ_REPLY        2
`define CRQ_IRQ_TX_OVER      3
`define CRQ_IRQ_RX_UNDER     4
`define CRQ_RAW_RX_BIT       8
`define CRQ_RAW_TX_BIT       9
`endif

// ---- test/crq_chk.sv ----
// Assertions on the bus and register views of the reply and queue block.
`timescale 1ns/1ps
module crq_chk (
    input wire CORE_CLK, RSTN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
    input wire REPLY_VALID, TX_VALID, TX_READY, RX_VALID, RX_READY,
    input wire [13:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire rd = req && !WB_WE_I;
    a_ack_next: assert property (req |=> WB_ACK_O) else $error("no ack");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
    a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req)) else $error("stray ack");
    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 0) else $error("idle data");
    a_index_resv: assert property (rd && WB_ADR_I == 14'h20 |=> WB_DAT_O[31:6] == 0)
        else $error("index upper bits");
    a_top_resv: assert property (rd && WB_ADR_I == 14'h30 |=> WB_DAT_O[31:24] == 0)
        else $error("top word upper bits");
    a_purge_wo: assert property (rd && WB_ADR_I == 14'h34 |=> WB_DAT_O[31:16] == 0)
        else $error("purge bits read back");
    a_count_max: assert property (rd && WB_ADR_I == 14'h34 |=> WB_DAT_O[7:0] <= 8'h80)
        else $error("free count too big");
    cover property (REPLY_VALID);
    cover property (TX_VALID && TX_READY);
    cover property (RX_VALID && RX_READY);
endmodule // crq_chk
bind crq_top crq_chk chk (.*);

// ---- test/crq_card.sv ----
// Card-side model: reply source, transmit byte sink and receive byte source.
`timescale 1ns/1ps
module crq_card (
    input wire CORE_CLK, TX_VALID, RX_READY,
    input wire [7:0] TX_DATA,
    output reg REPLY_VALID = 0, TX_READY = 0, RX_VALID = 0,
    output reg [2:0] REPLY_TYPE = 0,
    output reg [5:0] REPLY_INDEX = 0,
    output reg [127:0] REPLY_BITS = 0,
    output reg [7:0] RX_DATA = 8'h5a
);
    logic [7:0] got[$];
    always @(posedge CORE_CLK) if (TX_VALID && TX_READY) got.push_back(TX_DATA);
    task sink(input r);
        @(posedge CORE_CLK);
        TX_READY <= r;
    endtask
    task reply(input [2:0] t, input [5:0] i, input [127:0] b);
        @(posedge CORE_CLK);
        {REPLY_VALID, REPLY_TYPE, REPLY_INDEX, REPLY_BITS} <= {1'b1, t, i, b};
        @(posedge CORE_CLK);
        // Stale bits are inverted so that a late capture cannot match by luck.
        {REPLY_VALID, REPLY_BITS} <= {1'b0, ~b};
    endtask
    task rx(input int n, input [7:0] d0);
        @(posedge CORE_CLK);
        for (int k = 0; k < n; k++) begin
            {RX_VALID, RX_DATA} <= {1'b1, d0 + 8'(k)};
            // The byte is taken at the edge at which ready is sampled high.
            do @(posedge CORE_CLK); while (RX_READY !== 1'b1);
        end
        {RX_VALID, RX_DATA} <= {1'b0, ~RX_DATA};
    endtask
endmodule // crq_card

// ---- test/crq_top_tb.sv ----
// Self-checking bench for the card reply and data queue.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module crq_top_tb;
    logic CORE_CLK = 0, RSTN = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic WB_ACK_O, IRQ, REPLY_VALID, TX_VALID, TX_READY, RX_VALID, RX_READY;
    logic [13:0] WB_ADR_I = 0;
    logic [3:0] WB_SEL_I = 0;
    logic [31:0] WB_DAT_I = 0, WB_DAT_O, d;
    logic [2:0] REPLY_TYPE;
    logic [5:0] REPLY_INDEX;
    logic [127:0] REPLY_BITS, b = 128'h0123456789abcdef_fedcba9876543210;
    logic [7:0] TX_DATA, RX_DATA;
    int fails = 0, num_checks = 0, cyc = 0;
    crq_top uut (.*);
    crq_card card (.*);
    always #10 CORE_CLK = ~CORE_CLK;
    task results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results;
        end
    end
    task bus(input w, input [13:0] a, input [3:0] s, input [31:0] wd);
        @(posedge CORE_CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'b11, w, a, s, wd};
        // The request stands until the edge at which ack is sampled high; data is taken there.
        do @(posedge CORE_CLK); while (WB_ACK_O !== 1'b1);
        d = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
    endtask
    task chk(input [13:0] a, input [31:0] e);
        bus(0, a, 4'hf, 0);
        `CHK("register", e, d)
    endtask
    task st(input [31:0] m, input [31:0] e);
        bus(0, 14'h3c, 4'hf, 0);
        `CHK("irq status", e, d & m)
    endtask
    task ick(input e);
        @(negedge CORE_CLK);
        `CHK("irq", e, IRQ)
    endtask
    initial begin
        repeat (20) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 10; i++) chk(14'(32 + 4 * i), i == 6 ? 32'h4040 : (i == 5) << 7);
        for (int t = 0; t < 4; t++) begin
            card.reply(3'(t), 6'h11 + 6'(t), b);
            chk(14'h20, t == 3 ? 32'h3f : 32'h11 + t);
            chk(14'h24, b[39:8]);
            chk(14'h28, t == 2 ? b[71:40] : 0);
            chk(14'h2c, t == 2 ? b[103:72] : 0);
            chk(14'h30, t == 2 ? b[127:104] : 0);
        end
        ick(0);
        bus(1, 14'h40, 4'hf, 32'h4);
        ick(1);
        bus(1, 14'h3c, 4'hf, 32'h4);
        ick(0);
        bus(1, 14'h38, 4'hf, 32'h0406);
        chk(14'h38, 32'h0406);
        bus(1, 14'h40, 4'hf, 32'h1f);
        bus(1, 14'h1000, 4'h1, 32'h11);
        bus(1, 14'h1ffe, 4'h3, 32'h3322);
        bus(1, 14'h1ffc, 4'hf, 32'h77665544);
        chk(14'h34, 32'h79);
        st(32'h3ff, 32'h202);
        ick(1);
        bus(1, 14'h3c, 4'hf, 32'h1f);
        card.sink(1);
        do bus(0, 14'h34, 4'hf, 0); while (d[7:0] !== 8'h80);
        card.sink(0);
        for (int k = 0; k < 7; k++) `CHK("tx byte", 8'h11 * (k + 1), card.got[k])
        for (int k = 0; k < 32; k++) bus(1, 14'h1000 + 14'(4 * k), 4'hf, k);
        chk(14'h34, 0);
        bus(1, 14'h1000, 4'h1, 32'h99);
        st(32'h8, 32'h8);
        bus(1, 14'h34, 4'h8, 32'h40000000);
        chk(14'h34, 32'h80);
        card.rx(6, 8'ha0);
        chk(14'h34, 32'h680);
        st(32'h101, 32'h101);
        bus(0, 14'h2000, 4'h1, 0);
        `CHK("rx byte", 8'ha0, d[7:0])
        bus(0, 14'h2ffe, 4'h3, 0);
        `CHK("rx half", 16'ha2a1, d[15:0])
        bus(0, 14'h2000, 4'hf, 0);
        st(32'h10, 32'h10);
        bus(1, 14'h34, 4'h8, 32'h80000000);
        chk(14'h34, 32'h80);
        results;
    end
endmodule // crq_top_tb
